// [ebhi_core.sv]
// External bus master with byte strobes, wait insertion and hold handshake
// Assumes an APB master, pins resolved outside, bus pins tristated by enables
//
// Behaviour
// - Accepted hold request stops accesses, grant low
// - In hold address, select, strobe and data pins float; bus clock stays driven
// - Grant stays low throughout hold state
// - Request high again ends hold, bus resumes
// - Reads drive read strobe, write strobes high
// - Writes strobe only lanes being written
// - Low wait input keeps adding wait cycles
// - Every access has at least one wait, two clocks minimum
// - Select bits 0-3 pick clock/wait/hold pins
// - Select bits 4-7 pick debug serial pins
// - Select register reads back as zero
// - Upper strobe lane 0-7, lower 8-15
// - Reads are sixteen bits, valid byte kept
// - Chip select by half; none for flash
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "ebhi_map.svh"

module ebhi_core
  import ebhi_pkg::*;
#(
  parameter logic [7:0]  BCLK_DIV  = `EBHI_BCLK_DIV,
  parameter logic [19:0] FLASH_TOP = `EBHI_FLASH_TOP
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  // Bus pins
  output ebhi_pins_s       extBus,
  output logic             extBusOe,
  input  wire logic [15:0] extDataIn,
  output logic      [15:0] extDataOut,
  output logic             extDataOe,
  output logic             busClock,
  output logic             busClockOe,
  // Wait and hold pins
  input  wire logic        waitN,
  input  wire logic        holdRequestN,
  output logic             holdGrantN,
  output logic             holdGrantOe,
  // Pin function selects
  output logic      [7:0]  port7FunctionSelect
);

  localparam int REG_NONE = 0;
  localparam int REG_P7 = 1;
  localparam int REG_ADDR = 2;
  localparam int REG_WDATA = 3;
  localparam int REG_CTRL = 4;
  localparam int REG_STAT = 5;

  function automatic logic [2:0] regSel(
    input logic [31:0] a
  );
    logic [2:0] r;
    r = 3'(REG_NONE);
    if (a[1:0] == 2'h0) begin
      unique case (a[31:2])
        `EBHI_IDX_P7SEL:  r = 3'(REG_P7);
        `EBHI_IDX_XADDR:  r = 3'(REG_ADDR);
        `EBHI_IDX_XWDATA: r = 3'(REG_WDATA);
        `EBHI_IDX_XCTRL:  r = 3'(REG_CTRL);
        `EBHI_IDX_XSTAT:  r = 3'(REG_STAT);
        default:          r = 3'(REG_NONE);
      endcase
    end
    return r;
  endfunction : regSel

  ebhi_state_e state;
  ebhi_req_s   req;
  ebhi_req_s   cur;
  logic [2:0]  hreqSync;
  logic [2:0]  waitSync;
  logic [15:0] dSync0;
  logic [15:0] dSync1;
  logic [15:0] dSync2;
  logic        hreqLvl;
  logic        waitLvl;
  logic [7:0]  divCnt;
  logic        goPend;
  logic        errFlag;
  logic [15:0] rdWord;
  logic [7:0]  rdByte;
  logic        apbAcc;
  logic        apbWr;
  logic [2:0]  wrSel;
  logic        tick;
  logic        holdWant;
  logic        flashHit;
  logic        accept;
  logic        refuse;
  logic        startCyc;
  logic        endCyc;
  logic        enterHold;
  logic        leaveHold;
  logic        resume;

  // Pin synchronisers; a change counts when stages two and three agree
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      hreqSync <= 3'h7;
      waitSync <= 3'h7;
      hreqLvl  <= 1'b1;
      waitLvl  <= 1'b1;
    end else begin
      hreqSync <= {hreqSync[1:0], holdRequestN};
      waitSync <= {waitSync[1:0], waitN};
      if (hreqSync[1] == hreqSync[2]) begin
        hreqLvl <= hreqSync[2];
      end
      if (waitSync[1] == waitSync[2]) begin
        waitLvl <= waitSync[2];
      end
    end
  end

  // Data lines held stable by the far side until strobes rise
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      dSync0 <= 16'h0000;
      dSync1 <= 16'h0000;
      dSync2 <= 16'h0000;
    end else begin
      dSync0 <= extDataIn;
      dSync1 <= dSync0;
      dSync2 <= dSync1;
    end
  end

  // Bus clock divider; tick marks each bus clock rising edge
  assign tick = (divCnt == BCLK_DIV - 8'h01);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      divCnt   <= 8'h00;
      busClock <= 1'b0;
    end else begin
      divCnt   <= tick ? 8'h00 : divCnt + 8'h01;
      busClock <= tick || (divCnt < (BCLK_DIV >> 1) - 8'h01);
    end
  end

  // APB answers one cycle into the access phase
  assign apbAcc = psel && penable;
  assign apbWr  = apbAcc && pready && pwrite;
  assign wrSel  = regSel(paddr);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pready <= 1'b0;
    end else begin
      pready <= apbAcc && !pready;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (apbAcc && !pready) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
      unique case (wrSel)
        3'(REG_P7):    prdata <= 32'h00000000;
        3'(REG_ADDR):  prdata <= {12'h000, req.addr};
        3'(REG_WDATA): prdata <= {16'h0000, req.wdata};
        3'(REG_CTRL):  prdata <= {28'h0000000, req.lowerEn,
                                  req.upperEn, req.write, 1'b0};
        3'(REG_STAT):  prdata <= {rdWord, rdByte, 5'h00, errFlag,
                                  state == ST_HOLD, goPend ||
                                  (state == ST_ADDR) ||
                                  (state == ST_WAIT)};
        default:       pslverr <= 1'b1;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      port7FunctionSelect <= `EBHI_P7_RST;
    end else if (apbWr && wrSel == 3'(REG_P7)) begin
      port7FunctionSelect <= pwdata[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      req <= '0;
    end else if (apbWr) begin
      if (wrSel == 3'(REG_ADDR)) begin
        req.addr <= pwdata[19:0];
      end
      if (wrSel == 3'(REG_WDATA)) begin
        req.wdata <= pwdata[15:0];
      end
      if (wrSel == 3'(REG_CTRL)) begin
        req.write   <= pwdata[`EBHI_CTL_WRITE];
        req.upperEn <= pwdata[`EBHI_CTL_UPPER];
        req.lowerEn <= pwdata[`EBHI_CTL_LOWER];
      end
    end
  end

  // Cycle sequencing
  assign holdWant = port7FunctionSelect[`EBHI_P7_HOLD_REQUEST_N] && !hreqLvl;
  assign flashHit = !req.addr[19] && (req.addr < FLASH_TOP);
  assign accept   = tick && state == ST_IDLE && goPend && !holdWant;
  assign refuse   = accept && flashHit;
  assign startCyc = accept && !flashHit;
  assign endCyc   = tick && state == ST_WAIT &&
                    !(port7FunctionSelect[`EBHI_P7_WAIT] && !waitLvl);
  assign enterHold = tick && state == ST_IDLE && holdWant;
  assign leaveHold = tick && state == ST_HOLD && !holdWant;
  assign resume    = tick && state == ST_HEXIT;

  // Set from software wins over the clear on acceptance
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      goPend <= 1'b0;
    end else if (apbWr && wrSel == 3'(REG_CTRL) && pwdata[`EBHI_CTL_GO]) begin
      goPend <= 1'b1;
    end else if (accept) begin
      goPend <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      errFlag <= 1'b0;
    end else if (refuse) begin
      errFlag <= 1'b1;
    end else if (apbWr && wrSel == 3'(REG_CTRL) && pwdata[`EBHI_CTL_CLRERR]) begin
      errFlag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (enterHold) begin
            state <= ST_HOLD;
          end else if (startCyc) begin
            state <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (tick) begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (endCyc) begin
            state <= ST_IDLE;
          end
        end
        ST_HOLD: begin
          if (leaveHold) begin
            state <= ST_HEXIT;
          end
        end
        ST_HEXIT: begin
          if (resume) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cur <= '0;
    end else if (startCyc) begin
      cur <= req;
    end
  end

  // Address, selects and strobes
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      extBus <= '{18'h00000, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    end else if (startCyc) begin
      extBus.extAddressLines       <= req.addr[18:1];
      extBus.extSelectFirstN       <= req.addr[19];
      extBus.extSelectSecondN      <= !req.addr[19];
      extBus.readStrobeN           <= req.write;
      extBus.upperByteWriteStrobeN <= !(req.write && req.upperEn);
      extBus.lowerByteWriteStrobeN <= !(req.write && req.lowerEn);
    end else if (endCyc) begin
      extBus.extSelectFirstN       <= 1'b1;
      extBus.extSelectSecondN      <= 1'b1;
      extBus.readStrobeN           <= 1'b1;
      extBus.upperByteWriteStrobeN <= 1'b1;
      extBus.lowerByteWriteStrobeN <= 1'b1;
    end
  end

  // Upper lane is bits 15:8 (lines 0-7), lower lane bits 7:0
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      extDataOut <= 16'h0000;
      extDataOe  <= 1'b0;
    end else if (startCyc) begin
      extDataOut <= req.wdata;
      extDataOe  <= req.write;
    end else if (endCyc || enterHold) begin
      extDataOe  <= 1'b0;
    end
  end

  // Drive is released in hold and taken back only after grant rises
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      extBusOe   <= 1'b1;
      holdGrantN <= 1'b1;
    end else if (enterHold) begin
      extBusOe   <= 1'b0;
      holdGrantN <= 1'b0;
    end else if (leaveHold) begin
      holdGrantN <= 1'b1;
    end else if (resume) begin
      extBusOe   <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      holdGrantOe <= 1'b0;
      busClockOe  <= 1'b0;
    end else begin
      holdGrantOe <= port7FunctionSelect[`EBHI_P7_HGNT];
      busClockOe  <= port7FunctionSelect[`EBHI_P7_BCLK];
    end
  end

  // Reads always take the full word, then keep the valid byte
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rdWord <= 16'h0000;
      rdByte <= 8'h00;
    end else if (endCyc && !cur.write) begin
      rdWord <= dSync2;
      rdByte <= (cur.upperEn || (!cur.lowerEn && !cur.addr[0])) ?
                dSync2[15:8] : dSync2[7:0];
    end
  end

endmodule : ebhi_core

// [ebhi_core_checker.sv]
// Pin-level assertions for ebhi_core
// Bound to ebhi_core; sees its ports only
`timescale 1ns/1ps
module ebhi_core_checker
  import ebhi_pkg::*;
(
  // Clock, reset
  input wire logic       core_clk,
  input wire logic       nrst,
  // APB
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  // Pins
  input wire ebhi_pins_s extBus,
  input wire logic       extBusOe,
  input wire logic       extDataOe,
  input wire logic       holdRequestN,
  input wire logic       holdGrantN,
  input wire logic [7:0] port7FunctionSelect
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic act, wr;
  assign act = !(extBus.extSelectFirstN && extBus.extSelectSecondN);
  assign wr = !(extBus.upperByteWriteStrobeN && extBus.lowerByteWriteStrobeN);
  a_apb_answer: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  a_hold_float: assert property (!holdGrantN |-> !extBusOe && !extDataOe)
    else $error("pins driven in hold");
  a_read_strobes: assert property (!extBus.readStrobeN |-> !wr && !extDataOe)
    else $error("write strobe in read");
  a_write_lanes: assert property (wr |-> extDataOe && extBus.readStrobeN)
    else $error("write strobe without data");
  a_min_cycle: assert property ($rose(act) |-> act[*8])
    else $error("cycle too short");
  a_one_select: assert property (extBus.extSelectFirstN || extBus.extSelectSecondN)
    else $error("both selects low");
  a_grant_cause: assert property ($fell(holdGrantN) |->
    port7FunctionSelect[2] && !holdRequestN && !$past(act)) else $error("grant early");
  a_release_order: assert property ($rose(holdGrantN) |-> (!extBusOe)[*2])
    else $error("pins driven with grant");
  cover property ($fell(holdGrantN));
  cover property ($rose(act) ##1 act[*8]);
  cover property (wr);
endmodule : ebhi_core_checker

bind ebhi_core ebhi_core_checker chk_i (.core_clk, .nrst, .psel, .penable, .pready, .extBus,
  .extBusOe, .extDataOe, .holdRequestN, .holdGrantN, .port7FunctionSelect);

// [ebhi_core_tb_top.sv]
// Bench for ebhi_core: APB tasks, far-side model, pin checks
// Assumes the checker binds itself; released pins pull high
`timescale 1ns/1ps
module ebhi_core_tb_top;
  import ebhi_pkg::*;
  localparam logic [31:0] B = 32'h02001d80;
  logic        core_clk = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0;
  logic        pwrite = 1'h0, wantHold = 1'h0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0;
  logic [7:0]  waitLen = 8'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er, extBusOe, extDataOe, holdGrantN, waitN, holdRequestN;
  logic [15:0] extDataIn, extDataOut;
  logic [7:0]  p7;
  logic        bclk, bclkOe, grantOe;
  logic [4:0]  stb;
  ebhi_pins_s  extBus, pins;
  int          mismatches = 0, compares = 0, len;
  always #5 core_clk = ~core_clk;
  assign pins = extBusOe ? extBus : '1;
  ebhi_core DUT (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .extBus, .extBusOe, .extDataIn, .extDataOut, .extDataOe,
    .busClock(bclk), .busClockOe(bclkOe), .waitN, .holdRequestN, .holdGrantN,
    .holdGrantOe(grantOe),
    .port7FunctionSelect(p7));
  ebhi_far_model far (.core_clk, .extBus(pins), .extDataOut, .waitLen, .wantHold,
    .extDataIn, .waitN, .holdRequestN);
  task automatic conclude;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic step(inout int n);
    @(posedge core_clk);
    if (++n > 3000) begin
      mismatches++;
      conclude();
    end
  endtask : step
  task automatic apb(input logic w, input logic [31:0] a, d);
    int n = 0;
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge core_clk);
    penable <= 1'h1;
    do step(n); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
    #1;
  endtask : apb
  // Times one external cycle; h raises a hold request as it starts
  task automatic cyc(input logic h);
    int n = 0;
    len = 0;
    while (pins.extSelectFirstN & pins.extSelectSecondN) step(n);
    wantHold <= h;
    stb = pins[4:0];
    while (!(pins.extSelectFirstN & pins.extSelectSecondN)) begin
      if (h) chk(holdGrantN, 1'h1);
      step(n);
      len++;
    end
  endtask : cyc
  task automatic t_regs;
    int hi = 0;
    apb(1'h1, 32'h02001d1c, 32'hff);
    chk(p7, 8'hff);
    apb(1'h0, 32'h02001d1c, 32'h0);
    chk(rd, 32'h0);
    chk({bclkOe, grantOe}, 2'h3);
    repeat (8) begin
      @(posedge core_clk);
      hi += bclk;
    end
    chk(hi, 32'h4);
    apb(1'h1, 32'h02001d20, 32'h0);
    chk(er, 1'h1);
    $display("t_regs end");
  endtask : t_regs
  task automatic t_wr(input logic [3:0] c, input logic [15:0] m);
    apb(1'h1, B, 32'h80010);
    apb(1'h1, B + 32'h4, 32'ha55a);
    apb(1'h1, B + 32'h8, {28'h0, c});
    cyc(1'h0);
    chk(len, 32'h8);
    chk(stb, {3'h5, ~c[2], ~c[3]});
    chk(pins.extAddressLines, 18'h8);
    chk(far.mem, m);
    $display("t_wr end");
  endtask : t_wr
  task automatic t_rd;
    int n = 0;
    @(posedge core_clk) waitLen <= 8'h14;
    apb(1'h1, B + 32'h8, 32'h5);
    cyc(1'h0);
    chk(stb, 5'h13);
    chk(len > 20 && len % 4 == 0, 1'h1);
    apb(1'h0, B + 32'hc, 32'h0);
    chk(rd[31:8], 24'ha55aa5);
    apb(1'h1, B, 32'h100);
    apb(1'h1, B + 32'h8, 32'h5);
    // The refusal lands at the next bus tick, so wait for busy to drop
    do begin
      step(n);
      apb(1'h0, B + 32'hc, 32'h0);
    end while (rd[0] !== 1'h0);
    chk(rd[2:0], 3'h4);
    apb(1'h1, B + 32'h8, 32'h10);
    apb(1'h0, B + 32'hc, 32'h0);
    chk(rd[2], 1'h0);
    $display("t_rd end");
  endtask : t_rd
  task automatic t_hold;
    int n = 0;
    apb(1'h1, B, 32'h80010);
    apb(1'h1, B + 32'h8, 32'h5);
    cyc(1'h1);
    while (holdGrantN !== 1'h0) step(n);
    chk({extBusOe, extDataOe}, 2'h0);
    apb(1'h1, B + 32'h8, 32'h5);
    repeat (10) begin
      step(n);
      chk({holdGrantN, extBus.readStrobeN}, 2'h1);
    end
    wantHold <= 1'h0;
    while (holdGrantN !== 1'h1) step(n);
    chk(extBusOe, 1'h0);
    cyc(1'h0);
    chk(len > 20, 1'h1);
    $display("t_hold end");
  endtask : t_hold
  initial begin
    repeat (4) @(posedge core_clk);
    nrst <= 1'h1;
    t_regs();
    t_wr(4'h7, 16'ha534);
    t_wr(4'hb, 16'ha55a);
    t_rd();
    t_hold();
    conclude();
  end
endmodule : ebhi_core_tb_top

// [ebhi_far_model.sv]
// Far side: one 16-bit memory word, a wait stretcher and a hold master
// Assumes resolved pins; released lines show the inverse, not stale data
`timescale 1ns/1ps
module ebhi_far_model
  import ebhi_pkg::*;
(
  // Clock
  input wire logic        core_clk,
  // From the device
  input wire ebhi_pins_s  extBus,
  input wire logic [15:0] extDataOut,
  // Bench controls
  input wire logic [7:0]  waitLen,
  input wire logic        wantHold,
  // To the device
  output logic     [15:0] extDataIn,
  output logic            waitN,
  output logic            holdRequestN
);
  logic [15:0] mem = 16'h1234;
  logic [7:0]  cnt = 8'h0;
  logic        act;
  assign act = !(extBus.extSelectFirstN && extBus.extSelectSecondN);
  assign extDataIn = extBus.readStrobeN ? ~mem : mem;
  assign waitN = cnt >= waitLen;
  // Master only asks; it never drives the bus, even once granted
  assign holdRequestN = !wantHold;
  always_ff @(posedge core_clk) begin
    cnt <= act ? cnt + 8'h1 : 8'h0;
    if (!extBus.upperByteWriteStrobeN) mem[15:8] <= extDataOut[15:8];
    if (!extBus.lowerByteWriteStrobeN) mem[7:0] <= extDataOut[7:0];
  end
endmodule : ebhi_far_model

// [ebhi_map.svh]
// Register indices, field positions, reset values and timing counts
// Assumes APB byte address = register index * 4
`ifndef EBHI_MAP_SVH
`define EBHI_MAP_SVH
`define EBHI_IDX_P7SEL     30'h00800747
`define EBHI_IDX_XADDR     30'h00800760
`define EBHI_IDX_XWDATA    30'h00800761
`define EBHI_IDX_XCTRL     30'h00800762
`define EBHI_IDX_XSTAT     30'h00800763
`define EBHI_P7_BCLK       0
`define EBHI_P7_WAIT       1
`define EBHI_P7_HOLD_REQUEST_N       2
`define EBHI_P7_HGNT       3
`define EBHI_P7_RST        8'h00
`define EBHI_CTL_GO        0
`define EBHI_CTL_WRITE     1
`define EBHI_CTL_UPPER     2
`define EBHI_CTL_LOWER     3
`define EBHI_CTL_CLRERR    4
`define EBHI_ST_BUSY       0
`define EBHI_ST_HOLD       1
`define EBHI_ST_ERR        2
`define EBHI_BCLK_DIV      8'h04
`define EBHI_FLASH_TOP     20'h20000
`endif

// [ebhi_pkg.sv]
// Types shared by the external bus and hold block
// Assumes ebhi_map.svh supplies all numeric constants
package ebhi_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_WAIT  = 3'b010,
    ST_HOLD  = 3'b011,
    ST_HEXIT = 3'b100
  } ebhi_state_e;

  typedef struct packed {
    logic [17:0] extAddressLines;
    logic        extSelectFirstN;
    logic        extSelectSecondN;
    logic        readStrobeN;
    logic        upperByteWriteStrobeN;
    logic        lowerByteWriteStrobeN;
  } ebhi_pins_s;

  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] wdata;
    logic        write;
    logic        upperEn;
    logic        lowerEn;
  } ebhi_req_s;
endpackage : ebhi_pkg
